// >>> fpl_pkg.sv
package fpl_pkg;

  // ****************************************************
  // Register offsets
  // ****************************************************
  localparam logic [7:0] OUT1_SHUTOFF_OFS = 8'h33;
  localparam logic [7:0] OUT2_SHUTOFF_OFS = 8'h34;
  localparam logic [7:0] BINDINGS_OFS     = 8'h35;
  localparam logic [7:0] FLOOR_HYST_OFS   = 8'h36;

  // ****************************************************
  // Reset values
  // ****************************************************
  localparam logic [7:0] OUT1_SHUTOFF_RST = 8'h00;
  localparam logic [7:0] OUT2_SHUTOFF_RST = 8'h00;
  localparam logic [7:0] BINDINGS_RST     = 8'h30;
  localparam logic [7:0] FLOOR_HYST_RST   = 8'h00;

  // ****************************************************
  // Field positions
  // ****************************************************
  localparam int CUTOFF_MSB   = 7;
  localparam int CUTOFF_LSB   = 3;
  localparam int BIND_LOOP_Z1 = 0;
  localparam int BIND_LOOP_Z2 = 1;
  localparam int BIND_OUT1_PI = 2;
  localparam int BIND_OUT2_PI = 3;
  localparam int BIND_TBL_LSB = 4;
  localparam int HYST_MSB     = 3;
  localparam int HYST_LSB     = 0;
  localparam int FLOOR_MSB    = 7;
  localparam int FLOOR_LSB    = 4;

  // ****************************************************
  // Widths and scaling
  // ****************************************************
  localparam int DUTY_W       = 9;
  localparam int TEMP_W       = 9;
  localparam int COEF_W       = 3;
  localparam int TABLES       = 4;
  localparam int OUTPUTS      = 2;
  localparam int CUTOFF_SHIFT = 3;
  localparam int FLOOR_SHIFT  = 4;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

endpackage

// >>> fpl_out_gate.sv
`timescale 1ns/1ns
module fpl_out_gate (
  // Requested duty
  input  wire logic [fpl_pkg::DUTY_W-1:0] duty_in,
  // Settings
  input  wire logic [4:0]                 cutoff_duty,
  input  wire logic [fpl_pkg::COEF_W-1:0] smoothing_coef,
  // Result
  output logic      [fpl_pkg::DUTY_W-1:0] duty_out,
  output logic                            forced_off
);

  logic [fpl_pkg::DUTY_W-1:0] threshold;
  logic                       gate_on;

  // ****************************************************
  // Shutoff comparison
  // ****************************************************
  assign threshold  = {{(fpl_pkg::DUTY_W-8){1'b0}}, cutoff_duty, 3'h0};
  assign gate_on    = (smoothing_coef != 3'h0);
  assign forced_off = gate_on && (duty_in < threshold);
  assign duty_out   = forced_off ? {fpl_pkg::DUTY_W{1'b0}} : duty_in;

endmodule

// >>> fpl_ctrl.sv
`timescale 1ns/1ns
module fpl_ctrl (
  // Clock and reset
  input  wire logic                              clk,
  input  wire logic                              rst,
  // Register port
  input  wire logic [7:0]                        reg_addr,
  input  wire logic                              reg_wr,
  input  wire logic [7:0]                        reg_wdata,
  input  wire logic                              reg_rd,
  output logic      [7:0]                        reg_rdata,
  // Filter coefficients
  input  wire logic [fpl_pkg::COEF_W-1:0]        out1_smoothing_coef,
  input  wire logic [fpl_pkg::COEF_W-1:0]        out2_smoothing_coef,
  // Zone temperatures, half degree units
  input  wire logic [fpl_pkg::TEMP_W-1:0]        zone1_temp,
  input  wire logic [fpl_pkg::TEMP_W-1:0]        zone2_temp,
  input  wire logic [fpl_pkg::TEMP_W-1:0]        zone3_temp,
  input  wire logic [fpl_pkg::TEMP_W-1:0]        zone4_temp,
  input  wire logic [fpl_pkg::TEMP_W-1:0]        loop_target,
  // Duty sources
  input  wire logic [fpl_pkg::DUTY_W-1:0]        loop_duty,
  input  wire logic                              loop_active,
  input  wire logic                              loop_forced_off,
  input  wire logic [fpl_pkg::DUTY_W-1:0]        out1_table_duty,
  input  wire logic [fpl_pkg::DUTY_W-1:0]        out2_table_duty,
  // Table inputs
  output logic      [fpl_pkg::TEMP_W-1:0]        table1_temp,
  output logic      [fpl_pkg::TEMP_W-1:0]        table2_temp,
  output logic      [fpl_pkg::TEMP_W-1:0]        table3_temp,
  output logic      [fpl_pkg::TEMP_W-1:0]        table4_temp,
  // Loop feedback
  output logic      [fpl_pkg::TEMP_W-1:0]        loop_temp,
  output logic                              loop_temp_valid,
  output logic                              loop_above_target,
  output logic                              loop_below_window,
  output logic      [fpl_pkg::DUTY_W-1:0]        loop_duty_held,
  // Fan outputs
  output logic      [fpl_pkg::DUTY_W-1:0]        out1_duty,
  output logic      [fpl_pkg::DUTY_W-1:0]        out2_duty,
  output logic                              out1_off,
  output logic                              out2_off
);

  // ****************************************************
  // Registers
  // ****************************************************
  logic [4:0] out1_cutoff_duty_reg;
  logic [4:0] out2_cutoff_duty_reg;
  logic [7:0] bindings_reg;
  logic [3:0] loop_hysteresis_reg;
  logic [3:0] loop_floor_duty_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out1_cutoff_duty_reg <= fpl_pkg::OUT1_SHUTOFF_RST[fpl_pkg::CUTOFF_MSB:fpl_pkg::CUTOFF_LSB];
      out2_cutoff_duty_reg <= fpl_pkg::OUT2_SHUTOFF_RST[fpl_pkg::CUTOFF_MSB:fpl_pkg::CUTOFF_LSB];
      bindings_reg         <= fpl_pkg::BINDINGS_RST;
      loop_hysteresis_reg  <= fpl_pkg::FLOOR_HYST_RST[fpl_pkg::HYST_MSB:fpl_pkg::HYST_LSB];
      loop_floor_duty_reg  <= fpl_pkg::FLOOR_HYST_RST[fpl_pkg::FLOOR_MSB:fpl_pkg::FLOOR_LSB];
    end else if (reg_wr) begin
      case (reg_addr)
        fpl_pkg::OUT1_SHUTOFF_OFS: begin
          out1_cutoff_duty_reg <= reg_wdata[fpl_pkg::CUTOFF_MSB:fpl_pkg::CUTOFF_LSB];
        end
        fpl_pkg::OUT2_SHUTOFF_OFS: begin
          out2_cutoff_duty_reg <= reg_wdata[fpl_pkg::CUTOFF_MSB:fpl_pkg::CUTOFF_LSB];
        end
        fpl_pkg::BINDINGS_OFS: begin
          bindings_reg <= reg_wdata;
        end
        fpl_pkg::FLOOR_HYST_OFS: begin
          loop_hysteresis_reg <= reg_wdata[fpl_pkg::HYST_MSB:fpl_pkg::HYST_LSB];
          loop_floor_duty_reg <= reg_wdata[fpl_pkg::FLOOR_MSB:fpl_pkg::FLOOR_LSB];
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************************
  // Read back
  // ****************************************************
  logic [7:0] rdata_next;

  always_comb begin
    case (reg_addr)
      fpl_pkg::OUT1_SHUTOFF_OFS: rdata_next = {out1_cutoff_duty_reg, 3'h0};
      fpl_pkg::OUT2_SHUTOFF_OFS: rdata_next = {out2_cutoff_duty_reg, 3'h0};
      fpl_pkg::BINDINGS_OFS:     rdata_next = bindings_reg;
      fpl_pkg::FLOOR_HYST_OFS:   rdata_next = {loop_floor_duty_reg, loop_hysteresis_reg};
      default:                   rdata_next = fpl_pkg::RD_UNMAPPED;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= fpl_pkg::RD_UNMAPPED;
    end else if (reg_rd) begin
      reg_rdata <= rdata_next;
    end
  end

  // ****************************************************
  // Table source selection
  // ****************************************************
  function automatic logic [fpl_pkg::TEMP_W-1:0] zone_pick(
    input logic                       use_cpu,
    input logic [fpl_pkg::TEMP_W-1:0] cpu_temp,
    input logic [fpl_pkg::TEMP_W-1:0] other_temp
  );
    zone_pick = use_cpu ? cpu_temp : other_temp;
  endfunction

  logic [fpl_pkg::TEMP_W-1:0] table_sel [fpl_pkg::TABLES];

  genvar t;
  generate
    for (t = 0; t < fpl_pkg::TABLES; t++) begin : g_table
      // Even tables pair zone one with zone three, odd ones zone two with zone four
      if (t % 2 == 0) begin : g_even
        assign table_sel[t] = zone_pick(bindings_reg[fpl_pkg::BIND_TBL_LSB + t],
                                        zone1_temp, zone3_temp);
      end else begin : g_odd
        assign table_sel[t] = zone_pick(bindings_reg[fpl_pkg::BIND_TBL_LSB + t],
                                        zone2_temp, zone4_temp);
      end
    end
  endgenerate

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      table1_temp <= '0;
      table2_temp <= '0;
      table3_temp <= '0;
      table4_temp <= '0;
    end else begin
      table1_temp <= table_sel[0];
      table2_temp <= table_sel[1];
      table3_temp <= table_sel[2];
      table4_temp <= table_sel[3];
    end
  end

  // ****************************************************
  // Loop temperature and window
  // ****************************************************
  logic                       use_z1;
  logic                       use_z2;
  logic [fpl_pkg::TEMP_W-1:0] hotter;
  logic [fpl_pkg::TEMP_W-1:0] window_low;

  assign use_z1 = bindings_reg[fpl_pkg::BIND_LOOP_Z1];
  assign use_z2 = bindings_reg[fpl_pkg::BIND_LOOP_Z2];

  always_comb begin
    if (use_z1 && use_z2) begin
      hotter = ($signed(zone1_temp) > $signed(zone2_temp)) ? zone1_temp : zone2_temp;
    end else if (use_z1) begin
      hotter = zone1_temp;
    end else if (use_z2) begin
      hotter = zone2_temp;
    end else begin
      hotter = '0;
    end
  end

  assign window_low = loop_target - {{(fpl_pkg::TEMP_W-4){1'b0}}, loop_hysteresis_reg};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      loop_temp         <= '0;
      loop_temp_valid   <= 1'b0;
      loop_above_target <= 1'b0;
      loop_below_window <= 1'b0;
    end else begin
      loop_temp         <= hotter;
      loop_temp_valid   <= use_z1 || use_z2;
      loop_above_target <= (use_z1 || use_z2) && ($signed(hotter) > $signed(loop_target));
      loop_below_window <= (use_z1 || use_z2) && ($signed(hotter) < $signed(window_low));
    end
  end

  // ****************************************************
  // Loop floor duty
  // ****************************************************
  logic [fpl_pkg::DUTY_W-1:0] floor_duty;
  logic [fpl_pkg::DUTY_W-1:0] loop_clamped;

  assign floor_duty = {1'b0, loop_floor_duty_reg, 4'h0};

  always_comb begin
    if (!loop_active || loop_forced_off) begin
      loop_clamped = '0;
    end else if (loop_duty < floor_duty) begin
      loop_clamped = floor_duty;
    end else begin
      loop_clamped = loop_duty;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      loop_duty_held <= '0;
    end else begin
      loop_duty_held <= loop_clamped;
    end
  end

  // ****************************************************
  // Output selection and shutoff
  // ****************************************************
  logic [fpl_pkg::DUTY_W-1:0] out_sel   [fpl_pkg::OUTPUTS];
  logic [fpl_pkg::DUTY_W-1:0] out_gated [fpl_pkg::OUTPUTS];
  logic                       out_cut   [fpl_pkg::OUTPUTS];

  assign out_sel[0] = bindings_reg[fpl_pkg::BIND_OUT1_PI] ? loop_clamped : out1_table_duty;
  assign out_sel[1] = bindings_reg[fpl_pkg::BIND_OUT2_PI] ? loop_clamped : out2_table_duty;

  fpl_out_gate u_gate1 (
    .duty_in        (out_sel[0]),
    .cutoff_duty    (out1_cutoff_duty_reg),
    .smoothing_coef (out1_smoothing_coef),
    .duty_out       (out_gated[0]),
    .forced_off     (out_cut[0])
  );

  fpl_out_gate u_gate2 (
    .duty_in        (out_sel[1]),
    .cutoff_duty    (out2_cutoff_duty_reg),
    .smoothing_coef (out2_smoothing_coef),
    .duty_out       (out_gated[1]),
    .forced_off     (out_cut[1])
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out1_duty <= '0;
      out2_duty <= '0;
      out1_off  <= 1'b0;
      out2_off  <= 1'b0;
    end else begin
      out1_duty <= out_gated[0];
      out2_duty <= out_gated[1];
      out1_off  <= out_cut[0];
      out2_off  <= out_cut[1];
    end
  end

endmodule

// >>> fpl_ctrl_chk.sv
`timescale 1ns/1ns
// ****
// Port checker
// ****
module fpl_ctrl_chk (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // Output one
  input wire logic [2:0] out1_smoothing_coef,
  input wire logic [8:0] out1_table_duty,
  input wire logic [8:0] out1_duty,
  input wire logic       out1_off
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic       run;
  logic [7:0] thr_sh;
  logic [7:0] bnd_sh;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      run    <= 1'b0;
      thr_sh <= 8'h00;
      bnd_sh <= 8'h30;
    end else begin
      run <= 1'b1;
      if (reg_wr && reg_addr == 8'h33) thr_sh <= reg_wdata;
      if (reg_wr && reg_addr == 8'h35) bnd_sh <= reg_wdata;
    end
  end
  property p_rd_unmapped; reg_rd && !(reg_addr inside {[8'h33:8'h36]}) |=> reg_rdata == 8'h00; endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
  property p_rd_cut1; reg_rd && reg_addr == 8'h33 |=> reg_rdata == ($past(thr_sh) & 8'hF8); endproperty
  a_rd_cut1: assert property (p_rd_cut1) else $error("cutoff one readback wrong");
  property p_rd_cut2; reg_rd && reg_addr == 8'h34 |=> reg_rdata[2:0] == 3'h0; endproperty
  a_rd_cut2: assert property (p_rd_cut2) else $error("cutoff two low bits not zero");
  property p_rd_bind; reg_rd && reg_addr == 8'h35 |=> reg_rdata == $past(bnd_sh); endproperty
  a_rd_bind: assert property (p_rd_bind) else $error("bindings readback wrong");
  property p_off_zero; out1_off |-> out1_duty == 9'h000; endproperty
  a_off_zero: assert property (p_off_zero) else $error("output one off with duty");
  property p_bypass; run && $past(out1_smoothing_coef) == 3'h0 |-> !out1_off; endproperty
  a_bypass: assert property (p_bypass) else $error("shutoff with filter bypassed");
  property p_table_src; run && $past(out1_smoothing_coef) == 3'h0 && ($past(bnd_sh) & 8'h04) == 8'h00
    |-> out1_duty == $past(out1_table_duty); endproperty
  a_table_src: assert property (p_table_src) else $error("output one not from table");
  property p_cut; run && $past(out1_smoothing_coef) != 3'h0 && ($past(bnd_sh) & 8'h04) == 8'h00
    && $past(out1_table_duty) < {1'b0, $past(thr_sh) & 8'hF8} |-> out1_off; endproperty
  a_cut: assert property (p_cut) else $error("output one not cut below threshold");
endmodule
bind fpl_ctrl fpl_ctrl_chk i_fpl_ctrl_chk (.clk, .rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
  .out1_smoothing_coef, .out1_table_duty, .out1_duty, .out1_off);

// >>> fpl_fan_model.sv
`timescale 1ns/1ns
// ****
// Fan behaviour
// ****
module fpl_fan_model (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // Drive and state
  input wire logic [8:0] duty,
  input wire logic       off,
  output logic           spinning
);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) spinning <= 1'b0;
    else spinning <= !off && duty != 9'h000;
  end
endmodule

// >>> fpl_ctrl_tb.sv
`timescale 1ns/1ns
// ****
// Testbench
// ****
module fpl_ctrl_tb;
  logic       clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, loop_active = 1'b0, loop_forced_off = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [2:0] out1_smoothing_coef = 3'h0, out2_smoothing_coef = 3'h0;
  logic [8:0] zone1_temp = 9'h011, zone2_temp = 9'h022, zone3_temp = 9'h033, zone4_temp = 9'h044;
  logic [8:0] loop_target = 9'h000, loop_duty = 9'h000, out1_table_duty = 9'h000, out2_table_duty = 9'h005;
  logic [8:0] table1_temp, table2_temp, table3_temp, table4_temp, loop_temp, loop_duty_held, out1_duty, out2_duty;
  logic       loop_temp_valid, loop_above_target, loop_below_window, out1_off, out2_off, fan1_spin, fan2_spin;
  logic [7:0] bnd [4] = '{8'h00, 8'hF0, 8'h50, 8'hA0};
  logic [4:0] fld [3] = '{5'h01, 5'h02, 5'h1F};
  int         fails = 0, comparisons = 0;
  always #10 clk = ~clk;
  fpl_ctrl i_fpl_ctrl (.clk, .rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .out1_smoothing_coef,
    .out2_smoothing_coef, .zone1_temp, .zone2_temp, .zone3_temp, .zone4_temp, .loop_target, .loop_duty,
    .loop_active, .loop_forced_off, .out1_table_duty, .out2_table_duty, .table1_temp, .table2_temp, .table3_temp,
    .table4_temp, .loop_temp, .loop_temp_valid, .loop_above_target, .loop_below_window, .loop_duty_held,
    .out1_duty, .out2_duty, .out1_off, .out2_off);
  fpl_fan_model i_fpl_fan_model_1 (.clk, .rst, .duty(out1_duty), .off(out1_off), .spinning(fan1_spin));
  fpl_fan_model i_fpl_fan_model_2 (.clk, .rst, .duty(out2_duty), .off(out2_off), .spinning(fan2_spin));
  task automatic check(logic [8:0] seen, logic [8:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic acc(logic w, logic [7:0] a, logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = w;
    reg_rd = ~w;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    if (!w) check({1'b0, reg_rdata}, {1'b0, d});
  endtask
  task automatic conclude;
    $display("Counts: %0d comparisons, %0d fails", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge clk);
    rst = 1'b0;
    acc(1'b0, 8'h34, 8'h00);
    acc(1'b0, 8'h35, 8'h30);
    acc(1'b0, 8'h36, 8'h00);
    acc(1'b0, 8'h33, 8'h00);
    acc(1'b1, 8'h33, 8'hFF);
    acc(1'b0, 8'h33, 8'hF8);
    acc(1'b1, 8'h37, 8'hFF);
    acc(1'b0, 8'h37, 8'h00);
    foreach (bnd[i]) begin
      acc(1'b1, 8'h35, bnd[i]);
      @(negedge clk);
      check(table1_temp, bnd[i][4] ? zone1_temp : zone3_temp);
      check(table2_temp, bnd[i][5] ? zone2_temp : zone4_temp);
      check(table3_temp, bnd[i][6] ? zone1_temp : zone3_temp);
      check(table4_temp, bnd[i][7] ? zone2_temp : zone4_temp);
    end
    out1_smoothing_coef = 3'h1;
    out2_smoothing_coef = 3'h1;
    foreach (fld[i]) begin
      acc(1'b1, 8'h33, {fld[i], 3'h0});
      out1_table_duty = {1'b0, fld[i], 3'h0} - 9'h001;
      @(negedge clk);
      check({8'h00, out1_off}, 9'h001);
      out1_table_duty = {1'b0, fld[i], 3'h0};
      @(negedge clk);
      check(out1_duty, out1_table_duty);
    end
    check(out2_duty, 9'h005);
    acc(1'b1, 8'h34, 8'h17);
    out2_table_duty = 9'h00F;
    out1_smoothing_coef = 3'h0;
    out1_table_duty = 9'h007;
    @(negedge clk);
    @(negedge clk);
    check({8'h00, out2_off}, 9'h001);
    check({8'h00, fan2_spin}, 9'h000);
    check(out1_duty, 9'h007);
    check({8'h00, fan1_spin}, 9'h001);
    acc(1'b0, 8'h34, 8'h10);
    out2_smoothing_coef = 3'h0;
    acc(1'b1, 8'h36, 8'h40);
    acc(1'b1, 8'h35, 8'h0C);
    loop_active = 1'b1;
    loop_duty = 9'h020;
    @(negedge clk);
    check(loop_duty_held, 9'h040);
    check(out1_duty, 9'h040);
    check(out2_duty, 9'h040);
    check({8'h00, loop_temp_valid}, 9'h000);
    loop_forced_off = 1'b1;
    @(negedge clk);
    check(out1_duty, 9'h000);
    check(loop_duty_held, 9'h000);
    acc(1'b1, 8'h35, 8'h03);
    zone1_temp = 9'h01E;
    zone2_temp = 9'h028;
    loop_target = 9'h021;
    @(negedge clk);
    check(loop_temp, 9'h028);
    check({8'h00, loop_temp_valid}, 9'h001);
    check({8'h00, loop_above_target}, 9'h001);
    acc(1'b1, 8'h35, 8'h01);
    @(negedge clk);
    check(loop_temp, 9'h01E);
    check({8'h00, loop_below_window}, 9'h001);
    acc(1'b1, 8'h36, 8'h44);
    @(negedge clk);
    check({8'h00, loop_below_window}, 9'h000);
    conclude;
  end
endmodule
